//--- design/rco_top.sv
// Reference clock output control: register file, prescaler and output pin control.
// Assumes ref_tick_i pulses once per half period of the 16 MHz reference, in the core clock.
//
// Functional notes
// R01: Output clock is the 16 MHz reference prescaled to 16..1 MHz, 250 kHz or symbol rate.
// R02: With defer bit 0 or current rate 0, a new rate applies at once.
// R03: With defer bit 1 and rate nonzero, new rate waits for next sleep exit.
// R04: Reset keeps the running output rate while the rate field reads back 1.
// R05: Without rewrite after reset the output falls back to 1 MHz after sleep.
// R06: Software should rewrite the old rate after reset to match the output.
// R07: Clock pin drive is 2, 4, 6 or 8 mA from a 2-bit field, reset 4 mA.
// R08: Control register 0x03 holds I/O drive, clock drive, defer bit and rate.
// R09: Oscillator register 0x12 selects crystal oscillator or external reference.
// R10: Trim field selects 0 to 4.5 pF in 0.3 pF steps; more lowers frequency.
// R11: Software should select external mode when an external reference is used.
// R12: Jitter module jitters receiver clocks and I/O including the clock output only.
// R13: Rate codes: 0 off low, 1..5 are 1..16 MHz, 6 250 kHz, 7 symbol rate.
// R14: Mode 0x4 disables the crystal oscillator, 0xf enables it; others reserved.
// R15: Rate changes never produce runt pulses or glitches on the output pin.
`include "rco_regs.svh"

module rco_top (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       por_i,
  input  wire logic [5:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_we_i,
  input  wire logic       reg_re_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       ref_tick_i,
  input  wire logic       sleep_i,
  input  wire logic       bpsk_sel_i,
  input  wire logic       sub_mode_i,
  output logic            ref_clock_out_o,
  output logic      [1:0] clkout_drive_sel_o,
  output logic      [1:0] io_drive_sel_o,
  output logic            crystal_oscillator_en_o,
  output logic            ext_ref_sel_o,
  output logic      [3:0] osc_cap_trim_o,
  output logic            rx_jitter_en_o
);
  import rco_pkg::*;

  // ****************************************************************
  // Register file state
  // ****************************************************************
  logic [7:0]  out_ctrl;
  logic [7:0]  next_out_ctrl;
  logic [7:0]  rx_ctrl;
  logic [7:0]  next_rx_ctrl;
  logic [7:0]  osc_ctrl;
  logic [7:0]  next_osc_ctrl;
  logic [7:0]  rdata;
  logic [7:0]  next_rdata;

  // ****************************************************************
  // Shadowed rate state, kept across rst_i
  // ****************************************************************
  rco_rate_t   target_rate;
  rco_rate_t   next_target_rate;
  logic        pending;
  logic        next_pending;
  logic        sleep_q;
  logic        next_sleep_q;

  // ****************************************************************
  // Output generator state
  // ****************************************************************
  rco_phase_e  phase;
  rco_phase_e  next_phase;
  rco_rate_t   run_rate;
  rco_rate_t   next_run_rate;
  logic [9:0]  cnt;
  logic [9:0]  next_cnt;
  logic [7:0]  lfsr;
  logic [7:0]  next_lfsr;
  logic        clk_out;
  logic        next_clk_out;
  logic [1:0]  run_sym;
  logic [1:0]  next_run_sym;

  logic        wr_out_ctrl;
  logic [7:0]  status_word;
  logic [9:0]  sym_half;
  logic        sleep_exit;
  logic        jit_en;
  logic [9:0]  half_len;
  logic [10:0] half_lim;
  logic        half_done;

  // ****************************************************************
  // Register writes and read port
  // ****************************************************************
  assign wr_out_ctrl = reg_we_i && (reg_addr_i == `RCO_OFS_OUT_CTRL);
  assign jit_en      = rx_ctrl[`RCO_JIT_BIT];

  always_comb begin
    next_out_ctrl = out_ctrl;
    next_rx_ctrl  = rx_ctrl;
    next_osc_ctrl = osc_ctrl;
    if (reg_we_i) begin
      unique case (reg_addr_i)
        `RCO_OFS_OUT_CTRL: next_out_ctrl = reg_wdata_i; // [R08] [R07]
        `RCO_OFS_RX_CTRL:  next_rx_ctrl  = reg_wdata_i; // [R12]
        `RCO_OFS_OSC_CTRL: next_osc_ctrl = reg_wdata_i; // [R09] [R10] [R14]
        default:           next_out_ctrl = out_ctrl;
      endcase
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        `RCO_OFS_OUT_CTRL: next_rdata = out_ctrl; // [R04]
        `RCO_OFS_RX_CTRL:  next_rdata = rx_ctrl;
        `RCO_OFS_OSC_CTRL: next_rdata = osc_ctrl;
        `RCO_OFS_STATUS:   next_rdata = status_word;
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Status view
  // ****************************************************************
  // The shadow and the running rate are visible here, since after rst_i the
  // rate field may disagree with what the pin is doing.
  assign status_word = {1'b0, target_rate, pending, run_rate}; // [R04]

  // The software view is cleared by rst_i, the running rate is not.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || por_i) begin
      out_ctrl <= `RCO_OUT_CTRL_RST; // [R04]
      rx_ctrl  <= `RCO_RX_CTRL_RST;
      osc_ctrl <= `RCO_OSC_CTRL_RST;
      rdata    <= 8'h00;
    end else begin
      out_ctrl <= next_out_ctrl;
      rx_ctrl  <= next_rx_ctrl;
      osc_ctrl <= next_osc_ctrl;
      rdata    <= next_rdata;
    end
  end

  // ****************************************************************
  // Rate update scheme
  // ****************************************************************
  assign sleep_exit = sleep_q && !sleep_i;

  always_comb begin
    next_target_rate = target_rate;
    next_pending     = pending;
    next_sleep_q     = sleep_i;
    if (sleep_exit) begin
      next_target_rate = out_ctrl[`RCO_RATE_HI:`RCO_RATE_LO]; // [R03] [R05]
      next_pending     = 1'b0;
    end
    if (wr_out_ctrl && !rst_i) begin
      if (!out_ctrl[`RCO_DEFER_BIT] ||
          (out_ctrl[`RCO_RATE_HI:`RCO_RATE_LO] == 3'h0)) begin
        next_target_rate = reg_wdata_i[`RCO_RATE_HI:`RCO_RATE_LO]; // [R02]
        next_pending     = 1'b0;
      end else begin
        next_pending     = 1'b1; // [R03]
      end
    end
  end

  // Only power-on clears the shadow; rst_i leaves the pin rate untouched.
  always_ff @(posedge core_clk_i) begin
    if (por_i) begin
      target_rate <= `RCO_RATE_RST;
      pending     <= 1'b0;
      sleep_q     <= 1'b0;
    end else begin
      target_rate <= next_target_rate; // [R04]
      pending     <= next_pending;
      sleep_q     <= next_sleep_q;
    end
  end

  // ****************************************************************
  // Symbol rate selection
  // ****************************************************************
  // The modulation inputs are captured only where a new rate is taken, so a
  // modulation change in mid phase cannot cut a level short.
  always_comb begin
    unique case (run_sym) // [R13]
      2'b00:   sym_half = `RCO_HALF_SYM20K;
      2'b01:   sym_half = `RCO_HALF_SYM40K;
      2'b10:   sym_half = `RCO_HALF_SYM25K;
      default: sym_half = `RCO_HALF_SYM62K5;
    endcase
  end

  // ****************************************************************
  // Prescaler selection
  // ****************************************************************
  always_comb begin
    unique case (run_rate) // [R01] [R13]
      3'h1:    half_len = `RCO_HALF_1M;
      3'h2:    half_len = `RCO_HALF_2M;
      3'h3:    half_len = `RCO_HALF_4M;
      3'h4:    half_len = `RCO_HALF_8M;
      3'h5:    half_len = `RCO_HALF_16M;
      3'h6:    half_len = `RCO_HALF_250K;
      3'h7:    half_len = sym_half;
      default: half_len = `RCO_HALF_1M;
    endcase
  end

  // One extra tick on random half periods spreads the output harmonics.
  assign half_lim  = {1'b0, half_len} + {10'h000, jit_en & lfsr[0]}; // [R12]
  assign half_done = ref_tick_i && (({1'b0, cnt} + 11'h001) >= half_lim);

  // ****************************************************************
  // Output phase machine
  // ****************************************************************
  // New rates are taken only on leaving park or at the end of a full low phase, so every high and
  // low level has full length of either the old or the new rate.
  always_comb begin
    next_phase    = phase;
    next_run_rate = run_rate;
    next_run_sym  = run_sym;
    next_clk_out  = clk_out;
    next_cnt      = cnt;
    next_lfsr     = lfsr;
    if (ref_tick_i) begin
      next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      next_cnt  = half_done ? 10'h000 : cnt + 10'h001;
    end
    unique case (phase)
      RCO_PARK: begin
        next_clk_out = 1'b0; // [R13]
        next_cnt     = 10'h000;
        // Leaving park waits one cycle after sleep ends, so the rate taken on
        // wake-up is the one that the wake-up has just made current.
        if ((target_rate != 3'h0) && !sleep_i && !sleep_q) begin
          next_run_rate = target_rate; // [R03]
          next_run_sym  = {bpsk_sel_i, sub_mode_i};
          next_phase    = RCO_LOW;
        end
      end
      RCO_LOW: begin
        if (half_done) begin
          if ((target_rate == 3'h0) || sleep_i) begin
            next_phase = RCO_PARK;
          end else begin
            next_run_rate = target_rate; // [R15]
            next_run_sym  = {bpsk_sel_i, sub_mode_i}; // [R15]
            next_clk_out  = 1'b1;
            next_phase    = RCO_HIGH;
          end
        end
      end
      RCO_HIGH: begin
        if (half_done) begin
          next_clk_out = 1'b0; // [R15]
          next_phase   = RCO_LOW;
        end
      end
      default: begin
        next_clk_out = 1'b0;
        next_phase   = RCO_PARK;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (por_i) begin
      phase    <= RCO_PARK;
      run_rate <= `RCO_RATE_RST;
      run_sym  <= 2'b00;
      cnt      <= 10'h000;
      lfsr     <= 8'h01;
      clk_out  <= 1'b0;
    end else begin
      phase    <= next_phase;
      run_rate <= next_run_rate;
      run_sym  <= next_run_sym;
      cnt      <= next_cnt;
      lfsr     <= next_lfsr;
      clk_out  <= next_clk_out;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o        = rdata;
  assign ref_clock_out_o    = clk_out; // [R01]
  assign clkout_drive_sel_o = out_ctrl[`RCO_CLK_DRV_HI:`RCO_CLK_DRV_LO]; // [R07]
  assign io_drive_sel_o     = out_ctrl[`RCO_IO_DRV_HI:`RCO_IO_DRV_LO]; // [R08]
  assign osc_cap_trim_o     = osc_ctrl[`RCO_TRIM_HI:`RCO_TRIM_LO]; // [R10]
  // Reserved mode codes keep the crystal running, the safe default.
  assign crystal_oscillator_en_o =
    (osc_ctrl[`RCO_MODE_HI:`RCO_MODE_LO] != `RCO_MODE_EXT); // [R14]
  assign ext_ref_sel_o =
    (osc_ctrl[`RCO_MODE_HI:`RCO_MODE_LO] == `RCO_MODE_EXT); // [R09]
  assign rx_jitter_en_o     = jit_en; // [R12]

endmodule

//--- design/rco_regs.svh
// Register offsets, field positions, reset values and divider counts of the clock output block.
// Assumes an 8-bit register port with byte offsets as listed here.
`ifndef RCO_REGS_SVH
`define RCO_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RCO_OFS_OUT_CTRL    6'h03
`define RCO_OFS_RX_CTRL     6'h0a
`define RCO_OFS_OSC_CTRL    6'h12
`define RCO_OFS_STATUS      6'h1f

// ****************************************************************
// Field positions
// ****************************************************************
`define RCO_IO_DRV_HI       7
`define RCO_IO_DRV_LO       6
`define RCO_CLK_DRV_HI      5
`define RCO_CLK_DRV_LO      4
`define RCO_DEFER_BIT       3
`define RCO_RATE_HI         2
`define RCO_RATE_LO         0
`define RCO_JIT_BIT         5
`define RCO_MODE_HI         7
`define RCO_MODE_LO         4
`define RCO_TRIM_HI         3
`define RCO_TRIM_LO         0

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define RCO_OUT_CTRL_RST    8'h19
`define RCO_RX_CTRL_RST     8'h10
`define RCO_OSC_CTRL_RST    8'hf0
`define RCO_RATE_RST        3'h1
`define RCO_MODE_EXT        4'h4
`define RCO_MODE_XTAL       4'hf

// ****************************************************************
// Half periods in reference half-period ticks
// ****************************************************************
`define RCO_HALF_16M        10'h001
`define RCO_HALF_8M         10'h002
`define RCO_HALF_4M         10'h004
`define RCO_HALF_2M         10'h008
`define RCO_HALF_1M         10'h010
`define RCO_HALF_250K       10'h040
`define RCO_HALF_SYM20K     10'h320
`define RCO_HALF_SYM40K     10'h190
`define RCO_HALF_SYM25K     10'h280
`define RCO_HALF_SYM62K5    10'h100

`endif

//--- design/rco_pkg.sv
// Types shared by the clock output block.
// Assumes the constants of rco_regs.svh are included where needed.
package rco_pkg;

  // ****************************************************************
  // Output phase states
  // ****************************************************************
  typedef enum logic [2:0] {
    RCO_PARK = 3'b001,
    RCO_HIGH = 3'b010,
    RCO_LOW  = 3'b100
  } rco_phase_e;

  typedef logic [2:0] rco_rate_t;

endpackage

//--- verification/rco_checker.sv
// Concurrent checks on the ports of the clock output block.
// Assumes one core clock and synchronous resets rst_i and por_i.
module rco_checker (
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       por_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_we_i,
  input wire logic       reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       ref_tick_i,
  input wire logic       ref_clock_out_o,
  input wire logic [1:0] clkout_drive_sel_o,
  input wire logic [1:0] io_drive_sel_o,
  input wire logic       crystal_oscillator_en_o,
  input wire logic       ext_ref_sel_o,
  input wire logic [3:0] osc_cap_trim_o,
  input wire logic       rx_jitter_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wd_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i || por_i);
  // Write data kept one cycle, since $past cannot be sliced.
  always_ff @(posedge core_clk_i) begin
    wd_q <= reg_wdata_i;
  end
  rdata_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside answer cycle");
  pin_tick_a: assert property ($changed(ref_clock_out_o) |-> $past(ref_tick_i))
    else $error("clock pin moved without a reference tick");
  osc_excl_a: assert property (crystal_oscillator_en_o != ext_ref_sel_o)
    else $error("oscillator and external reference both or neither");
  trim_wr_a: assert property (reg_we_i && reg_addr_i == 6'h12 |=> osc_cap_trim_o == wd_q[3:0])
    else $error("trim output differs from written field");
  mode_wr_a: assert property (reg_we_i && reg_addr_i == 6'h12 |=>
    ext_ref_sel_o == (wd_q[7:4] == 4'h4))
    else $error("external reference select wrong after write");
  drive_wr_a: assert property (reg_we_i && reg_addr_i == 6'h03 |=>
    clkout_drive_sel_o == wd_q[5:4] && io_drive_sel_o == wd_q[7:6])
    else $error("drive codes differ from written fields");
  jit_wr_a: assert property (reg_we_i && reg_addr_i == 6'h0a |=> rx_jitter_en_o == wd_q[5])
    else $error("jitter enable differs from written bit");
  drive_rst_a: assert property (disable iff (por_i) rst_i |=>
    clkout_drive_sel_o == 2'h1 && io_drive_sel_o == 2'h0 && osc_cap_trim_o == 4'h0)
    else $error("drive or trim not at reset value after reset");
  osc_rd_a: assert property (reg_re_i && reg_addr_i == 6'h12 |=>
    reg_rdata_o[3:0] == osc_cap_trim_o)
    else $error("trim read back differs from trim output");
endmodule
bind rco_top rco_checker u_chk (.core_clk_i, .rst_i, .por_i, .reg_addr_i, .reg_wdata_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o, .ref_tick_i, .ref_clock_out_o, .clkout_drive_sel_o,
  .io_drive_sel_o, .crystal_oscillator_en_o, .ext_ref_sel_o, .osc_cap_trim_o, .rx_jitter_en_o);

//--- verification/rco_mcu_model.sv
// Model of the microcontroller that takes the divided clock.
// Assumes the reference tick arrives as an enable in the core clock.
module rco_mcu_model (
  input  wire logic        core_clk_i,
  input  wire logic        ref_tick_i,
  input  wire logic        clk_in_i,
  output logic      [11:0] hi_len_o,
  output logic      [11:0] lo_len_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] cnt;
  logic        prev;
  // Lengths are counted in ticks, so they do not depend on the tick spacing.
  always_ff @(posedge core_clk_i) begin
    prev <= clk_in_i;
    cnt  <= cnt + {11'h000, ref_tick_i};
    if (clk_in_i != prev) begin
      cnt <= {11'h000, ref_tick_i};
      if (prev) begin
        hi_len_o <= cnt;
      end else begin
        lo_len_o <= cnt;
      end
    end
  end
endmodule

//--- verification/reference_clock_output_control_tb.sv
// Self-checking bench of the clock output block with a clock consumer model.
// Assumes the design files and the checker are compiled before this file.
module reference_clock_output_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, rst_i, por_i, reg_we_i, reg_re_i, ref_tick_i, sleep_i;
  logic bpsk_sel_i, sub_mode_i, ref_clock_out_o, crystal_oscillator_en_o;
  logic ext_ref_sel_o, rx_jitter_en_o;
  logic [5:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o;
  logic [1:0]  clkout_drive_sel_o, io_drive_sel_o, tk;
  logic [3:0]  osc_cap_trim_o;
  logic [11:0] hi, lo;
  logic [11:0] hv [1:6] = '{12'h010, 12'h008, 12'h004, 12'h002, 12'h001, 12'h040};
  logic [11:0] sv [0:3] = '{12'h320, 12'h190, 12'h280, 12'h100};
  int n_fail, cmp_count, cyc;
  rco_top DUT (.core_clk_i, .rst_i, .por_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .reg_re_i, .reg_rdata_o, .ref_tick_i, .sleep_i, .bpsk_sel_i, .sub_mode_i,
    .ref_clock_out_o, .clkout_drive_sel_o, .io_drive_sel_o, .crystal_oscillator_en_o,
    .ext_ref_sel_o, .osc_cap_trim_o, .rx_jitter_en_o);
  rco_mcu_model u_mcu (.core_clk_i, .ref_tick_i, .clk_in_i(ref_clock_out_o),
    .hi_len_o(hi), .lo_len_o(lo));
  always #5 core_clk_i = ~core_clk_i;
  // Ticks skip every third cycle so that tick gating is really exercised.
  always @(posedge core_clk_i) begin
    tk <= (tk == 2'h2) ? 2'h0 : tk + 2'h1;
    ref_tick_i <= (tk != 2'h0);
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_we_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_re_i <= 1'b0;
    #1 chk("read data", {4'h0, e}, {4'h0, reg_rdata_o});
  endtask
  task automatic meas(input logic [11:0] h);
    repeat (3) @(posedge ref_clock_out_o);
    repeat (2) @(posedge core_clk_i);
    chk("high ticks", h, hi);
    chk("low ticks", h, lo);
  endtask
  task automatic slp;
    @(posedge core_clk_i);
    sleep_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    sleep_i <= 1'b0;
  endtask
  task automatic pulse_rst;
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic t_regs;
    rd(6'h03, 8'h19);
    rd(6'h0a, 8'h10);
    rd(6'h12, 8'hf0);
    rd(6'h20, 8'h00);
    chk("clock drive", 12'h1, {10'h0, clkout_drive_sel_o});
    chk("crystal on", 12'h1, {11'h0, crystal_oscillator_en_o});
    meas(12'h010);
    $display("test regs done");
  endtask
  task automatic t_rates;
    logic bad;
    for (int r = 1; r <= 6; r++) begin
      wr(6'h03, 8'h10 | r[7:0]);
      meas(hv[r]);
    end
    for (int m = 0; m < 4; m++) begin
      wr(6'h03, 8'h11);
      @(posedge core_clk_i);
      bpsk_sel_i <= m[1];
      sub_mode_i <= m[0];
      wr(6'h03, 8'h17);
      meas(sv[m]);
    end
    wr(6'h03, 8'h10);
    repeat (2000) @(posedge core_clk_i);
    bad = 1'b0;
    repeat (200) @(posedge core_clk_i) bad |= (ref_clock_out_o !== 1'b0);
    chk("parked pin", 12'h0, {11'h0, bad});
    for (int d = 0; d < 4; d++) begin
      wr(6'h03, {2'h2, d[1:0], 4'h0});
      chk("clock drive", d[11:0], {10'h0, clkout_drive_sel_o});
      rd(6'h03, {2'h2, d[1:0], 4'h0});
    end
    $display("test rates done");
  endtask
  task automatic t_defer;
    wr(6'h03, 8'h1d);
    meas(12'h001);
    wr(6'h03, 8'h1b);
    rd(6'h1f, 8'h5d);
    meas(12'h001);
    slp();
    meas(12'h004);
    rd(6'h1f, 8'h33);
    $display("test defer done");
  endtask
  task automatic t_shadow;
    pulse_rst();
    rd(6'h03, 8'h19);
    meas(12'h004);
    slp();
    meas(12'h010);
    wr(6'h03, 8'h1b);
    slp();
    pulse_rst();
    wr(6'h03, 8'h1b);
    meas(12'h004);
    slp();
    meas(12'h004);
    $display("test shadow done");
  endtask
  task automatic t_osc;
    wr(6'h12, 8'h4a);
    chk("external ref", 12'h1, {11'h0, ext_ref_sel_o});
    chk("crystal on", 12'h0, {11'h0, crystal_oscillator_en_o});
    chk("trim", 12'ha, {8'h0, osc_cap_trim_o});
    rd(6'h12, 8'h4a);
    wr(6'h12, 8'h3f);
    chk("crystal on", 12'h1, {11'h0, crystal_oscillator_en_o});
    chk("trim", 12'hf, {8'h0, osc_cap_trim_o});
    wr(6'h0a, 8'h30);
    chk("jitter", 12'h1, {11'h0, rx_jitter_en_o});
    rd(6'h0a, 8'h30);
    wr(6'h0a, 8'h10);
    chk("jitter", 12'h0, {11'h0, rx_jitter_en_o});
    $display("test oscillator done");
  endtask
  task automatic t_jitter;
    logic ok;
    logic grew;
    ok   = 1'b1;
    grew = 1'b0;
    wr(6'h0a, 8'h30);
    repeat (2) @(posedge ref_clock_out_o);
    repeat (16) begin
      @(posedge ref_clock_out_o);
      repeat (2) @(posedge core_clk_i);
      ok   &= (hi == 12'h004 || hi == 12'h005) && (lo == 12'h004 || lo == 12'h005);
      grew |= (hi == 12'h005) || (lo == 12'h005);
    end
    chk("jittered half length", 12'h1, {11'h0, ok});
    chk("jitter stretch seen", 12'h1, {11'h0, grew});
    wr(6'h0a, 8'h10);
    meas(12'h004);
    $display("test jitter done");
  endtask
  initial begin
    {core_clk_i, reg_we_i, reg_re_i, ref_tick_i, sleep_i, bpsk_sel_i, sub_mode_i} = '0;
    {rst_i, por_i} = 2'h3;
    {reg_addr_i, reg_wdata_i, tk} = 16'h0000;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    t_regs();
    t_rates();
    t_defer();
    t_shadow();
    t_osc();
    t_jitter();
    tally_and_finish();
  end
endmodule
